// ---- hw/mpc_defs.vh ----
// Constants for the multi-function pin configuration block.
// Included by the design file; definitions only.
`ifndef MPC_DEFS_VH
`define MPC_DEFS_VH
// Register byte offsets (one aligned 32-bit word each)
`define MPC_OFS_LINE1 8'h00
`define MPC_OFS_LINE2 8'h04
`define MPC_OFS_LINE3 8'h08
`define MPC_OFS_GROUP 8'h0C
`define MPC_OFS_AVG 8'h10
`define MPC_OFS_AMODE 8'h14
`define MPC_OFS_DUPLEX 8'h18
`define MPC_OFS_STATUS 8'h1C
`define MPC_OFS_CMD 8'h20
// Largest legal codes
`define MPC_LINE12_MAX 5'h04
`define MPC_LINE3_MAX 5'h14
`define MPC_GROUP_MAX 2'h1
`define MPC_AVG_MAX 2'h3
`define MPC_AMODE_MAX 2'h2
// Reset values
`define MPC_RST_CODE 5'h00
`define MPC_RST_GROUP 1'h0
`define MPC_RST_AVG 2'h0
`define MPC_RST_AMODE 2'h0
// Line 1/2 codes
`define MPC_L_UNUSED 5'h00
`define MPC_L_AIN 5'h01
`define MPC_L_SELFTEST 5'h02
`define MPC_L_AOUT 5'h03
`define MPC_L_ID 5'h04
// Line 3 codes
`define MPC_C_AIN 5'h01
`define MPC_C_AOUT 5'h03
`define MPC_C_ID 5'h04
`define MPC_C_DONE 5'h05
`define MPC_C_LOW 5'h06
`define MPC_C_HIGH 5'h07
`define MPC_C_HEAT_FIRST 5'h08
`define MPC_C_HEAT_LAST 5'h0D
`define MPC_C_SINGLE 5'h0E
`define MPC_C_CONT 5'h0F
`define MPC_C_BURST_HI 5'h10
`define MPC_C_BURST_LO 5'h11
`define MPC_C_DIR 5'h12
`define MPC_C_HSTAT 5'h13
`define MPC_C_HSTAT_HOUSING 5'h14
// Analog output modes
`define MPC_AMODE_VOLT 2'h0
`define MPC_AMODE_CURR 2'h1
`define MPC_AMODE_OFF 2'h2
// Thresholds
`define MPC_FILL_PCT 7'h50
`define MPC_DIR_LIMIT 9'h0AA
// Timing: trigger pulse least 1 us, burst pulse under 10 ms
`define MPC_CLK_HZ 50000000
`define MPC_PULSE_MIN_NS 1000
`define MPC_BURST_MAX_MS 10
`define MPC_ADC_FULL 16'hFFFF
`endif

// ---- hw/mpc_pin_config.v ----
// Multi-function connector line configuration with Avalon-MM register slave.
// Assumes all inputs are synchronous to ref_clk and a measurement engine
// that consumes the start pulses and reports its end.
// Notes on behaviour
// - Line one and two function writes are taken only in half duplex.
// - Line one code 0..4, reset 0; code 4 is identification bit 0.
// - Line one analog input sampled to 16 bits; disables speed analog output.
// - Code 2 reads back own speed output; line open, voltage mode needed.
// - Line two code 0..4, reset 0, mirrors line one for direction, id bit 1.
// - Line three function applies in half and full duplex alike.
// - Line three analog input gives 16-bit reading, top value 65535.
// - Line three: 2 reserved, 3 temperature output, 4 id bit 2.
// - Code 5 drives high once averaging buffer first exceeds 80 percent.
// - Code 6 drives low, code 7 drives high.
// - Codes 8..13 heating input; even active high; 10..13 add pulls.
// - Code 14 starts one measurement per rising edge; pulse over 1 us.
// - Code 15 starts continuous on rising edge; rewriting 15 stops it.
// - Code 16 pulse under 10 ms starts burst; held high restarts bursts.
// - Code 17 pull-up, low level starts burst; held low restarts bursts.
// - Code 18 drives high while direction below 170 degrees.
// - Codes 19, 20 output heating status; range ends at 20.
// - Output group 0 gives velocity components, 1 speed, direction, temperature.
// - Signed components centre at mid-scale; temperature fixed scaling.
// - Averaging method 0..3, reset 0; 3 vector speed, scalar angle.
// - Output mode changes only in half duplex; switches all lines.
// - Mode 0 voltage, 1 current, 2 disables calculation when all lines 0.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`include "mpc_defs.vh"
module mpc_pin_config #(
  parameter BURST_MAX_CYCLES = `MPC_BURST_MAX_MS * (`MPC_CLK_HZ / 1000)
) (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire line_three_in,
  input wire [15:0] adc_sample,
  input wire [6:0] buffer_fill_pct,
  input wire [8:0] wind_direction,
  input wire heating_on,
  input wire measurement_done,
  output reg line_three_out_ff,
  output reg line_three_oe_ff,
  output reg line_three_pullup_ff,
  output reg line_three_pulldown_ff,
  output reg [15:0] aux_reading_ff,
  output reg [2:0] external_unit_id_ff,
  output reg heat_request_ff,
  output reg single_start_ff,
  output reg cont_run_ff,
  output reg burst_start_ff,
  output reg speed_aout_en_ff,
  output reg dir_aout_en_ff,
  output reg temp_aout_en_ff,
  output reg analog_calc_en_ff,
  output reg [1:0] conv_slots_ff
);
  localparam integer PULSE_MIN_CYC = (`MPC_PULSE_MIN_NS * (`MPC_CLK_HZ / 1000000) + 999) / 1000;
  localparam integer BURST_MAX_INT = BURST_MAX_CYCLES - 1;
  localparam CW = 24;
  // Counters saturate, so 24 bits cover the 10 ms burst limit with room to spare
  localparam [CW-1:0] BURST_MAX = BURST_MAX_INT[CW-1:0];
  localparam [CW-1:0] PULSE_MIN = PULSE_MIN_CYC[CW-1:0];
  // Bus answer states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [4:0] line_one_function_ff;
  reg [4:0] line_two_function_ff;
  reg [4:0] line_three_function_ff;
  reg analog_output_group_ff;
  reg [1:0] averaging_method_ff;
  reg [1:0] analog_output_mode_ff;
  reg duplex_selection_ff;
  reg reject_ff;
  reg [1:0] state_ff;
  reg in_prev_ff;
  reg done_seen_ff;
  reg [CW-1:0] high_cnt_ff;
  reg burst_armed_ff;

  wire [7:0] addr = avs_address;
  wire wr_lo = avs_write && avs_byteenable[0] && state_ff == ST_IDLE;
  wire [4:0] wcode = avs_writedata[4:0];
  wire code_fits5 = avs_writedata[31:5] == 27'h0;

  function is_heat;
    input [4:0] c;
    begin
      is_heat = c >= `MPC_C_HEAT_FIRST && c <= `MPC_C_HEAT_LAST;
    end
  endfunction

  function is_analog;
    input [4:0] c;
    begin
      is_analog = c == `MPC_L_AIN || c == `MPC_L_SELFTEST || c == `MPC_L_AOUT;
    end
  endfunction

  wire fall = !line_three_in && in_prev_ff;
  wire all_zero = line_one_function_ff == `MPC_RST_CODE && line_two_function_ff == `MPC_RST_CODE &&
    line_three_function_ff == `MPC_RST_CODE;
  wire any_analog = is_analog(line_one_function_ff) || is_analog(line_two_function_ff) ||
    line_three_function_ff == `MPC_C_AIN || line_three_function_ff == `MPC_C_AOUT;

  // Bus slave: one wait state, then answer; writes take effect at the answer edge
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (avs_read || avs_write) begin
            state_ff <= ST_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h0;
            if (avs_read) begin
              if (addr == `MPC_OFS_LINE1) begin
                avs_readdata <= {27'h0, line_one_function_ff};
              end else if (addr == `MPC_OFS_LINE2) begin
                avs_readdata <= {27'h0, line_two_function_ff};
              end else if (addr == `MPC_OFS_LINE3) begin
                avs_readdata <= {27'h0, line_three_function_ff};
              end else if (addr == `MPC_OFS_GROUP) begin
                avs_readdata <= {31'h0, analog_output_group_ff};
              end else if (addr == `MPC_OFS_AVG) begin
                avs_readdata <= {30'h0, averaging_method_ff};
              end else if (addr == `MPC_OFS_AMODE) begin
                avs_readdata <= {30'h0, analog_output_mode_ff};
              end else if (addr == `MPC_OFS_DUPLEX) begin
                avs_readdata <= {31'h0, duplex_selection_ff};
              end else if (addr == `MPC_OFS_STATUS) begin
                avs_readdata <= {10'h0, reject_ff, cont_run_ff, done_seen_ff, external_unit_id_ff, aux_reading_ff};
              end
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Parameter registers; out-of-range or duplex-locked writes keep the old value
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      line_one_function_ff <= `MPC_RST_CODE;
      line_two_function_ff <= `MPC_RST_CODE;
      line_three_function_ff <= `MPC_RST_CODE;
      analog_output_group_ff <= `MPC_RST_GROUP;
      averaging_method_ff <= `MPC_RST_AVG;
      analog_output_mode_ff <= `MPC_RST_AMODE;
      duplex_selection_ff <= 1'b0;
      reject_ff <= 1'b0;
    end else if (wr_lo) begin
      reject_ff <= 1'b0;
      if (addr == `MPC_OFS_LINE1) begin
        if (duplex_selection_ff && code_fits5 && wcode <= `MPC_LINE12_MAX) begin
          line_one_function_ff <= wcode;
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_LINE2) begin
        if (duplex_selection_ff && code_fits5 && wcode <= `MPC_LINE12_MAX) begin
          line_two_function_ff <= wcode;
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_LINE3) begin
        if (code_fits5 && wcode <= `MPC_LINE3_MAX) begin
          line_three_function_ff <= wcode;
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_GROUP) begin
        if (avs_writedata[31:1] == 31'h0) begin
          analog_output_group_ff <= avs_writedata[0];
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_AVG) begin
        if (avs_writedata[31:2] == 30'h0) begin
          averaging_method_ff <= avs_writedata[1:0];
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_AMODE) begin
        if (duplex_selection_ff && avs_writedata[31:2] == 30'h0 &&
            avs_writedata[1:0] <= `MPC_AMODE_MAX) begin
          analog_output_mode_ff <= avs_writedata[1:0];
        end else begin
          reject_ff <= 1'b1;
        end
      end else if (addr == `MPC_OFS_DUPLEX) begin
        // Full duplex needs lines one and two unused
        if (avs_writedata[0] || (line_one_function_ff == `MPC_L_UNUSED &&
            line_two_function_ff == `MPC_L_UNUSED)) begin
          duplex_selection_ff <= avs_writedata[0];
        end else begin
          reject_ff <= 1'b1;
        end
      end
    end
  end

  wire rewrite_cont = wr_lo && addr == `MPC_OFS_LINE3 && code_fits5 && wcode == `MPC_C_CONT;

  // Line three behaviour
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      in_prev_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      high_cnt_ff <= {CW{1'b0}};
      burst_armed_ff <= 1'b0;
      line_three_out_ff <= 1'b0;
      line_three_oe_ff <= 1'b0;
      line_three_pullup_ff <= 1'b0;
      line_three_pulldown_ff <= 1'b0;
      heat_request_ff <= 1'b0;
      single_start_ff <= 1'b0;
      cont_run_ff <= 1'b0;
      burst_start_ff <= 1'b0;
      external_unit_id_ff <= 3'h0;
      aux_reading_ff <= 16'h0;
    end else begin
      in_prev_ff <= line_three_in;
      single_start_ff <= 1'b0;
      burst_start_ff <= 1'b0;
      if (buffer_fill_pct > `MPC_FILL_PCT) begin
        done_seen_ff <= 1'b1;
      end
      if (line_three_in) begin
        high_cnt_ff <= (high_cnt_ff == {CW{1'b1}}) ? high_cnt_ff : high_cnt_ff + 1'b1;
      end else begin
        high_cnt_ff <= {CW{1'b0}};
      end
      line_three_oe_ff <= line_three_function_ff == `MPC_C_DONE || line_three_function_ff == `MPC_C_LOW ||
        line_three_function_ff == `MPC_C_HIGH || line_three_function_ff >= `MPC_C_DIR;
      line_three_pullup_ff <= line_three_function_ff == 5'h0A || line_three_function_ff == 5'h0D ||
        line_three_function_ff == `MPC_C_BURST_LO;
      line_three_pulldown_ff <= line_three_function_ff == 5'h0B || line_three_function_ff == 5'h0C ||
        line_three_function_ff == `MPC_C_SINGLE || line_three_function_ff == `MPC_C_CONT ||
        line_three_function_ff == `MPC_C_BURST_HI;
      case (line_three_function_ff)
        `MPC_C_DONE: line_three_out_ff <= done_seen_ff;
        `MPC_C_HIGH: line_three_out_ff <= 1'b1;
        `MPC_C_DIR: line_three_out_ff <= wind_direction < `MPC_DIR_LIMIT;
        `MPC_C_HSTAT: line_three_out_ff <= heating_on;
        `MPC_C_HSTAT_HOUSING: line_three_out_ff <= heating_on;
        default: line_three_out_ff <= 1'b0;
      endcase
      // Even codes sense active high, odd codes inverted
      heat_request_ff <= is_heat(line_three_function_ff) &&
        (line_three_in ^ line_three_function_ff[0]);
      // Trigger fires once the high level has lasted the least pulse time
      if (line_three_function_ff == `MPC_C_SINGLE && line_three_in && high_cnt_ff == PULSE_MIN - 1'b1) begin
        single_start_ff <= 1'b1;
      end
      if (rewrite_cont && line_three_function_ff == `MPC_C_CONT) begin
        cont_run_ff <= 1'b0;
      end else if (line_three_function_ff != `MPC_C_CONT) begin
        cont_run_ff <= 1'b0;
      end else if (line_three_in && high_cnt_ff == PULSE_MIN - 1'b1) begin
        cont_run_ff <= 1'b1;
      end
      // Burst: short high pulse (or low level for 17) starts; a held level restarts on done
      if (line_three_function_ff == `MPC_C_BURST_HI) begin
        if (fall && high_cnt_ff <= BURST_MAX) begin
          burst_start_ff <= 1'b1;
        end else if (line_three_in && high_cnt_ff > BURST_MAX && (high_cnt_ff == BURST_MAX + 1'b1 ||
            measurement_done)) begin
          burst_start_ff <= 1'b1;
        end
        burst_armed_ff <= 1'b0;
      end else if (line_three_function_ff == `MPC_C_BURST_LO) begin
        if (!line_three_in && (in_prev_ff || !burst_armed_ff || measurement_done)) begin
          burst_start_ff <= 1'b1;
        end
        burst_armed_ff <= !line_three_in;
      end else begin
        burst_armed_ff <= 1'b0;
      end
      if (line_three_function_ff == `MPC_C_ID) begin
        external_unit_id_ff[2] <= line_three_in;
      end
      // Line one/two id bits arrive through the shared converter sample MSB
      if (line_one_function_ff == `MPC_L_ID) begin
        external_unit_id_ff[0] <= adc_sample[15];
      end
      if (line_two_function_ff == `MPC_L_ID) begin
        external_unit_id_ff[1] <= adc_sample[15];
      end
      // One shared converter, so every analog input mode feeds the same reading
      if (line_three_function_ff == `MPC_C_AIN || is_analog(line_one_function_ff) &&
          line_one_function_ff != `MPC_L_AOUT || is_analog(line_two_function_ff) &&
          line_two_function_ff != `MPC_L_AOUT) begin
        aux_reading_ff <= adc_sample;
      end
    end
  end

  // Analog output enables; a line in analog input mode frees its output
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      speed_aout_en_ff <= 1'b0;
      dir_aout_en_ff <= 1'b0;
      temp_aout_en_ff <= 1'b0;
      analog_calc_en_ff <= 1'b1;
      conv_slots_ff <= 2'h0;
    end else begin
      speed_aout_en_ff <= analog_output_mode_ff != `MPC_AMODE_OFF &&
        (line_one_function_ff == `MPC_L_AOUT || line_one_function_ff == `MPC_L_SELFTEST);
      dir_aout_en_ff <= analog_output_mode_ff != `MPC_AMODE_OFF &&
        (line_two_function_ff == `MPC_L_AOUT || line_two_function_ff == `MPC_L_SELFTEST);
      temp_aout_en_ff <= analog_output_mode_ff != `MPC_AMODE_OFF &&
        line_three_function_ff == `MPC_C_AOUT;
      analog_calc_en_ff <= !(analog_output_mode_ff == `MPC_AMODE_OFF && all_zero) || any_analog;
      // Each line set to analog output code 3 adds one conversion slot of about 5 ms, whatever the output mode
      conv_slots_ff <= {1'b0, line_one_function_ff == `MPC_L_AOUT} + {1'b0, line_two_function_ff == `MPC_L_AOUT} +
        {1'b0, line_three_function_ff == `MPC_C_AOUT};
    end
  end
endmodule // mpc_pin_config

// ---- tb/mpc_line_partner.sv ----
// Equipment wired to the shared line, plus the measurement engine's end pulse.
// Assumes the bench steers ext_en/ext_lvl; inputs seen after each clock edge.
module mpc_line_partner #(
  parameter int DONE_DLY = 8
) (
  input wire ref_clk,
  input wire reset,
  input wire dev_out,
  input wire dev_oe,
  input wire pull_up,
  input wire pull_dn,
  input wire ext_en,
  input wire ext_lvl,
  input wire start,
  output logic line_lvl_ff,
  output logic meas_done_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      line_lvl_ff <= 1'b0;
      meas_done_ff <= 1'b0;
      cnt_ff <= 0;
    end else begin
      if (dev_oe) line_lvl_ff <= dev_out;
      else if (ext_en) line_lvl_ff <= ext_lvl;
      else if (pull_up) line_lvl_ff <= 1'b1;
      else if (pull_dn) line_lvl_ff <= 1'b0;
      else line_lvl_ff <= ~line_lvl_ff;
      meas_done_ff <= (cnt_ff == 1);
      if (start) cnt_ff <= DONE_DLY;
      else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule // mpc_line_partner

// ---- tb/mpc_pin_config_sva.sv ----
// Port-level assertions for the pin configuration block.
// Assumes one clock domain; bound into every mpc_pin_config instance.
module mpc_pin_config_sva (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire [8:0] wind_direction,
  input wire heating_on,
  input wire line_three_out_ff,
  input wire line_three_oe_ff,
  input wire line_three_pullup_ff,
  input wire line_three_pulldown_ff,
  input wire single_start_ff,
  input wire burst_start_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] code3_ff;
  wire take = avs_write && avs_waitrequest && avs_address == 8'h08 && avs_byteenable[0];
  // Shadow of the third line's code, so pin checks need no internal probe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) code3_ff <= 5'h00;
    else if (take && avs_writedata <= 32'h14) code3_ff <= avs_writedata[4:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_answer_delay: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  chk_drive_low: assert property (code3_ff == 5'h06 && $stable(code3_ff) |-> line_three_oe_ff && !line_three_out_ff)
    else $error("line not driven low");
  chk_drive_high: assert property (code3_ff == 5'h07 && $stable(code3_ff) |-> line_three_oe_ff && line_three_out_ff)
    else $error("line not driven high");
  chk_dir_limit: assert property (code3_ff == 5'h12 && $stable(code3_ff)
    |-> line_three_oe_ff && line_three_out_ff == ($past(wind_direction) < 9'h0AA))
    else $error("direction flag wrong");
  chk_heat_status: assert property (code3_ff == 5'h13 && $stable(code3_ff)
    |-> line_three_oe_ff && line_three_out_ff == $past(heating_on))
    else $error("heating status wrong");
  chk_pull_up: assert property ((code3_ff inside {5'h0A, 5'h0D, 5'h11}) && $stable(code3_ff)
    |-> line_three_pullup_ff && !line_three_pulldown_ff)
    else $error("pull-up not selected");
  chk_pull_down: assert property ((code3_ff inside {5'h0B, 5'h0C, 5'h10}) && $stable(code3_ff)
    |-> line_three_pulldown_ff && !line_three_pullup_ff)
    else $error("pull-down not selected");
  chk_single_pulse: assert property (single_start_ff |-> $past(code3_ff) == 5'h0E ##1 !single_start_ff)
    else $error("single start pulse wrong");
  cover property (single_start_ff);
  cover property (burst_start_ff);
  cover property (avs_read && !avs_waitrequest);
endmodule // mpc_pin_config_sva

bind mpc_pin_config mpc_pin_config_sva u_mpc_pin_config_sva (.ref_clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .wind_direction, .heating_on,
  .line_three_out_ff, .line_three_oe_ff, .line_three_pullup_ff, .line_three_pulldown_ff,
  .single_start_ff, .burst_start_ff);

// ---- tb/mpc_pin_config_tb.sv ----
// Self-checking bench for the pin configuration block.
// Assumes a short burst limit; the partner plays the wired equipment.
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end
module mpc_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] adc_sample = 16'h0;
  logic [15:0] adc_prev = 16'h0;
  logic [6:0] buffer_fill_pct = 7'h00;
  logic [8:0] wind_direction = 9'h000;
  logic heating_on = 1'b0;
  logic ext_en = 1'b1;
  logic ext_lvl = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, line_in, meas_done, l_out, l_oe, l_pu, l_pd, single_start_ff, burst_start_ff;
  wire cont_run_ff, speed_aout_en_ff, heat_req, dir_en, temp_en, calc_en;
  wire [15:0] aux_rd;
  wire [1:0] slots;
  int error_cnt = 0, check_count = 0, n_single = 0, n_burst = 0, i, k, v, cur;
  logic [31:0] exp_q[$], msk_q[$], e, m;
  logic [7:0] ofs[4] = '{8'h00, 8'h04, 8'h0C, 8'h10};
  int top[4] = '{4, 4, 1, 3};
  mpc_pin_config #(.BURST_MAX_CYCLES(20)) u_mpc_pin_config (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .line_three_in(line_in), .adc_sample(adc_sample), .buffer_fill_pct(buffer_fill_pct),
    .wind_direction(wind_direction), .heating_on(heating_on), .measurement_done(meas_done),
    .line_three_out_ff(l_out), .line_three_oe_ff(l_oe), .line_three_pullup_ff(l_pu),
    .line_three_pulldown_ff(l_pd), .aux_reading_ff(aux_rd), .external_unit_id_ff(), .heat_request_ff(heat_req),
    .single_start_ff(single_start_ff), .cont_run_ff(cont_run_ff), .burst_start_ff(burst_start_ff),
    .speed_aout_en_ff(speed_aout_en_ff), .dir_aout_en_ff(dir_en), .temp_aout_en_ff(temp_en),
    .analog_calc_en_ff(calc_en), .conv_slots_ff(slots));
  mpc_line_partner u_mpc_line_partner (.ref_clk(ref_clk), .reset(reset), .dev_out(l_out), .dev_oe(l_oe),
    .pull_up(l_pu), .pull_dn(l_pd), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .start(single_start_ff | burst_start_ff), .line_lvl_ff(line_in), .meas_done_ff(meas_done));
  initial forever #10 ref_clk = ~ref_clk;
  // Direction hovers around the 170 degree boundary on purpose
  always @(posedge ref_clk) begin
    wind_direction <= 9'h0A8 + 9'($urandom_range(3));
    heating_on <= 1'($urandom);
    adc_sample <= 16'($urandom);
    adc_prev <= adc_sample;
    n_single <= n_single + int'(single_start_ff === 1'b1);
    n_burst <= n_burst + int'(burst_start_ff === 1'b1);
  end
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("readdata", e, avs_readdata & m)
    end
  end
  task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rw;
    avs_write <= !rw;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk = 32'hFFFFFFFF);
    exp_q.push_back(x & mk);
    msk_q.push_back(mk);
    bus(1'b1, a, 32'h0);
  endtask
  task automatic pulse(input int hi);
    ext_lvl <= 1'b1;
    repeat (hi) @(posedge ref_clk);
    ext_lvl <= 1'b0;
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'h8D6B));
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h1C, 32'h200000, 32'h200000);
    wr(8'h08, 32'h7);
    rd(8'h08, 32'h7);
    `CHK("line level", 1'b1, l_out)
    avs_byteenable <= 4'hE;
    wr(8'h08, 32'h6);
    avs_byteenable <= 4'hF;
    rd(8'h08, 32'h7);
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h2);
    rd(8'h14, 32'h2);
    wr(8'h14, 32'h3);
    rd(8'h14, 32'h2);
    wr(8'h14, 32'h0);
    for (k = 0; k < 4; k++) begin
      cur = 0;
      for (i = 0; i < 8; i++) begin
        v = (i < 6) ? i : $urandom_range(top[k] + 2);
        wr(ofs[k], v);
        if (v <= top[k]) cur = v;
        rd(ofs[k], cur);
      end
    end
    wr(8'h00, 32'h3);
    repeat (3) @(posedge ref_clk);
    `CHK("speed output", 1'b1, speed_aout_en_ff)
    wr(8'h00, 32'h1);
    repeat (3) @(posedge ref_clk);
    `CHK("speed output", 1'b0, speed_aout_en_ff)
    `CHK("aux reading", adc_prev, aux_rd)
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h3);
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h1);
    `CHK("analog enables", 4'hE, {calc_en, dir_en, temp_en, speed_aout_en_ff})
    `CHK("conversion slots", 2'h2, slots)
    for (i = 0; i < 22; i++) begin
      wr(8'h08, i);
      rd(8'h08, (i > 20) ? 32'h14 : i);
      repeat (4) @(posedge ref_clk);
    end
    wr(8'h08, 32'h5);
    buffer_fill_pct <= 7'h50;
    repeat (4) @(posedge ref_clk);
    `CHK("fill flag", 1'b0, l_out)
    buffer_fill_pct <= 7'h51;
    repeat (4) @(posedge ref_clk);
    `CHK("fill flag", 1'b1, l_out)
    buffer_fill_pct <= 7'h00;
    repeat (4) @(posedge ref_clk);
    `CHK("fill flag", 1'b1, l_out)
    wr(8'h08, 32'h8);
    ext_lvl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("heat request", 1'b1, heat_req)
    wr(8'h08, 32'h9);
    repeat (4) @(posedge ref_clk);
    `CHK("heat request", 1'b0, heat_req)
    wr(8'h08, 32'h4);
    rd(8'h1C, 32'h40000, 32'h40000);
    ext_lvl <= 1'b0;
    wr(8'h08, 32'hE);
    v = n_single;
    pulse(20);
    `CHK("single count", v, n_single)
    pulse(60);
    `CHK("single count", v + 1, n_single)
    wr(8'h08, 32'hF);
    pulse(60);
    `CHK("continuous", 1'b1, cont_run_ff)
    wr(8'h08, 32'hF);
    repeat (3) @(posedge ref_clk);
    `CHK("continuous", 1'b0, cont_run_ff)
    wr(8'h08, 32'h10);
    v = n_burst;
    pulse(5);
    `CHK("burst count", v + 1, n_burst)
    v = n_burst;
    pulse(60);
    `CHK("burst restart", 1'b1, n_burst >= v + 2)
    ext_en <= 1'b0;
    wr(8'h08, 32'h11);
    repeat (10) @(posedge ref_clk);
    v = n_burst;
    repeat (10) @(posedge ref_clk);
    `CHK("open line burst", v, n_burst)
    ext_en <= 1'b1;
    repeat (40) @(posedge ref_clk);
    `CHK("held low burst", 1'b1, n_burst >= v + 2)
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h2);
    repeat (3) @(posedge ref_clk);
    `CHK("analog calc", 1'b0, calc_en)
    close_out();
  end
endmodule // mpc_pin_config_tb
